/* File: rtl/fpcr_pkg.sv */
package fpcr_pkg;

	// ---------------------------------------------------------------
	// Logical device numbers and register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] LDN_FLOPPY           = 8'h00;
	localparam logic [7:0] LDN_PPORT            = 8'h03;
	localparam logic [7:0] IDX_MODE             = 8'hF0;
	localparam logic [7:0] IDX_OPTION           = 8'hF1;
	localparam logic [7:0] IDX_DRIVE_TYPES      = 8'hF2;
	localparam logic [7:0] IDX_RESERVED_F3      = 8'hF3;
	localparam logic [7:0] IDX_DRIVE_ZERO       = 8'hF4;
	localparam logic [7:0] IDX_DRIVE_ONE        = 8'hF5;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_FLOPPY_MODE      = 8'h0E;
	localparam logic [7:0] RST_PARALLEL_MODE    = 8'h3C;
	localparam logic [7:0] RST_FLOPPY_OPTION    = 8'h00;
	localparam logic [7:0] RST_ROUTING          = 8'h00;
	localparam logic [7:0] RST_DRIVE_TYPES      = 8'hFF;
	localparam logic [7:0] RST_DRIVE_SETTINGS   = 8'h00;
	localparam logic [7:0] ZERO_BYTE            = 8'h00;

	// ---------------------------------------------------------------
	// Writable masks; clear bits are read-only zero
	// ---------------------------------------------------------------
	localparam logic [7:0] MASK_DRIVE_SETTINGS  = 8'h5B;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int FM_ENHANCED   = 0;
	localparam int FM_NON_BURST  = 1;
	localparam int FM_IFACE_LO   = 2;
	localparam int FM_PUSH_PULL  = 6;
	localparam int FM_TRISTATE   = 7;
	localparam int FO_FORCE_WP   = 0;
	localparam int FO_DENS_LO    = 2;
	localparam int DS_TYPE_LO    = 0;
	localparam int DS_RATE_LO    = 3;
	localparam int DS_PRECOMP    = 6;
	localparam int PM_MODE_LO    = 0;
	localparam int PM_THRESH_LO  = 3;
	localparam int PM_PULSE_IRQ  = 7;
	localparam int PR_ROUTE_LO   = 0;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] DENS_FORCE_ONE   = 2'h2;
	localparam logic [1:0] DENS_FORCE_ZERO  = 2'h3;
	localparam logic [2:0] PMODE_PRINTER    = 3'h4;
	localparam logic [2:0] PMODE_SPP        = 3'h0;
	localparam logic [2:0] PMODE_ECP        = 3'h2;
	localparam logic [1:0] ROUTE_NORMAL     = 2'h0;
	localparam logic [1:0] ROUTE_SPLIT      = 2'h1;
	localparam logic [1:0] ROUTE_ALL_PPORT  = 2'h2;
	localparam logic [1:0] BOOT_DRIVE       = 2'h0;

	// Interrupt style driven to the parallel port core.
	typedef enum logic [2:0]
	{
		FPCR_IRQ_NONE  = 3'b001,
		FPCR_IRQ_FOLLOW = 3'b010,
		FPCR_IRQ_PULSE = 3'b100
	} fpcr_irq_style_t;

endpackage

/* File: rtl/fpcr_sync2.sv */
`timescale 1ns/100ps
module fpcr_sync2
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_b_i,
	// Asynchronous level in, synchronised level out
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;

	// -----------------------------------------------------------
	// Two-stage synchroniser; the first stage feeds only the second.
	// -----------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= 1'b1;
			sync_o <= 1'b1;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

/* File: rtl/fpcr_drive_reg.sv */
`timescale 1ns/100ps
module fpcr_drive_reg
	import fpcr_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	// Write port
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wr_data_i,
	// Stored value and fields
	output logic      [7:0] value_o,
	output logic      [1:0] drive_type_select_o,
	output logic      [1:0] rate_table_select_o,
	output logic            precomp_disable_o
);

	// -----------------------------------------------------------
	// Per-drive settings; read-only bits never take a written one.
	// -----------------------------------------------------------
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			value_o <= RST_DRIVE_SETTINGS;
		else if (wr_en_i)
			value_o <= wr_data_i & MASK_DRIVE_SETTINGS;
	end

	// Field taps for the floppy core.
	assign drive_type_select_o = value_o[DS_TYPE_LO +: 2];
	assign rate_table_select_o = value_o[DS_RATE_LO +: 2];
	assign precomp_disable_o   = value_o[DS_PRECOMP];

endmodule

/* File: rtl/fpcr_top.sv */
// Summary of operation
// R1: Defaults only on power-on or hard reset.
// R2: Mode bit0 selects enhanced floppy mode two.
// R3: Mode bit1 selects non-burst DMA, default one.
// R4: Mode bits3:2 select host interface variant.
// R5: Mode bit6 selects push-pull floppy outputs.
// R6: Mode bit7 tri-states dedicated floppy outputs.
// R7: Driver controls affect dedicated floppy pins only.
// R8: Option bit0 forces write protect when selected.
// R9: Forced write protect also on parallel pins.
// R10: Option bits3:2 override density output.
// R11: Drive zero is always the boot drive.
// R12: Type register holds two drive codes.
// R13: Index F3 is reserved, reads zero.
// R14: Per-drive type and rate fields, others zero.
// R15: Per-drive bit6 disables write precompensation.
// R16: Drive one register mirrors drive zero layout.
// R17: Parallel mode bits2:0 select port mode.
// R18: Parallel bits6:3 hold FIFO threshold, 0111.
// R19: Bit7 selects pulsed or following interrupt.
// R20: Interrupt type ignored in printer, standard.
// R21: Routing bits1:0 place drives on pins.
// R22: Software writes zeros to reserved bits.
// R23: Strap picks configuration port address.
// R24: Read-only bits ignore writes, read zero.
`timescale 1ns/100ps
module fpcr_top
	import fpcr_pkg::*;
(
	// Clock and resets
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic       hard_reset_b_i,
	// Configuration port side, already decoded to logical device and index
	input  wire logic [7:0] ldn_i,
	input  wire logic [7:0] index_i,
	input  wire logic       cfg_wr_i,
	input  wire logic       cfg_rd_i,
	input  wire logic [7:0] cfg_wdata_i,
	output logic      [7:0] cfg_rdata_o,
	output logic            cfg_rvalid_o,
	// Strap for the configuration port address
	input  wire logic       config_port_strap_i,
	output logic            config_port_alt_o,
	// Floppy core controls
	output logic            floppy_enhanced_o,
	output logic            floppy_non_burst_o,
	output logic      [1:0] floppy_iface_mode_o,
	output logic            floppy_pins_push_pull_o,
	output logic            floppy_pins_tristate_o,
	output logic      [7:0] floppy_drive_types_o,
	output logic      [1:0] boot_drive_o,
	output logic      [1:0] drive0_type_select_o,
	output logic      [1:0] drive0_rate_table_select_o,
	output logic            drive0_precomp_disable_o,
	output logic      [1:0] drive1_type_select_o,
	output logic      [1:0] drive1_rate_table_select_o,
	output logic            drive1_precomp_disable_o,
	// Write protect and density
	input  wire logic       write_protect_in_n_i,
	input  wire logic [1:0] drive_select_i,
	input  wire logic       density_core_i,
	output logic            write_protect_core_n_o,
	output logic            density_o,
	// Parallel port controls
	output logic      [2:0] pport_mode_o,
	output logic      [3:0] ecp_fifo_threshold_o,
	output logic      [2:0] pport_irq_style_o,
	// Floppy routing onto pins
	output logic            drive0_on_pport_o,
	output logic            drive1_on_pport_o,
	output logic            pport_floppy_route_o
);

	// -----------------------------------------------------------
	// Storage
	// -----------------------------------------------------------
	logic [7:0] floppy_mode_cfg_q;
	logic [7:0] floppy_option_cfg_q;
	logic [7:0] floppy_drive_types_q;
	logic [7:0] parallel_mode_cfg_q;
	logic [7:0] parallel_floppy_routing_q;
	logic [7:0] drive_zero_settings;
	logic [7:0] drive_one_settings;
	logic [1:0] d0_type;
	logic [1:0] d0_rate;
	logic       d0_precomp;
	logic [1:0] d1_type;
	logic [1:0] d1_rate;
	logic       d1_precomp;
	logic       wp_sync;
	logic       dens_sync;
	logic       strap_meta_q;
	logic       hard_sync;
	logic       regs_rst_b;
	logic       sel_floppy;
	logic       sel_pport;
	logic       wr_floppy;
	logic       wr_pport;
	logic       any_drive_sel;
	logic       pp_irq_valid;
	logic [7:0] rdata_d;
	fpcr_irq_style_t irq_style_d;

	// -----------------------------------------------------------
	// Reset and input synchronisation
	// -----------------------------------------------------------

	// The hard reset pin is asynchronous, so it is synchronised first.
	fpcr_sync2 u_sync_hard
	(
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (hard_reset_b_i),
		.sync_o    (hard_sync)
	);

	// Write protect pin from the drive cable.
	fpcr_sync2 u_sync_wp
	(
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (write_protect_in_n_i),
		.sync_o    (wp_sync)
	);

	// Density request from the floppy core is treated as foreign too.
	fpcr_sync2 u_sync_dens
	(
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (density_core_i),
		.sync_o    (dens_sync)
	);

	// Power-on reset and the hard reset pin restore defaults; a soft reset
	// elsewhere in the chip is simply not connected here.
	assign regs_rst_b = rst_b_i & hard_sync; // R1

	// -----------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------
	assign sel_floppy = (ldn_i == LDN_FLOPPY);
	assign sel_pport  = (ldn_i == LDN_PPORT);
	assign wr_floppy  = cfg_wr_i & sel_floppy;
	assign wr_pport   = cfg_wr_i & sel_pport;

	// -----------------------------------------------------------
	// Floppy registers
	// -----------------------------------------------------------

	// Mode register; bit 5 is stored as written, software keeps it zero.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
			floppy_mode_cfg_q <= RST_FLOPPY_MODE; // R1
		else if (wr_floppy && index_i == IDX_MODE)
			floppy_mode_cfg_q <= cfg_wdata_i; // R22
	end

	// Option register.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
			floppy_option_cfg_q <= RST_FLOPPY_OPTION;
		else if (wr_floppy && index_i == IDX_OPTION)
			floppy_option_cfg_q <= cfg_wdata_i;
	end

	// Drive type codes; upper nibble is plain storage.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
			floppy_drive_types_q <= RST_DRIVE_TYPES;
		else if (wr_floppy && index_i == IDX_DRIVE_TYPES)
			floppy_drive_types_q <= cfg_wdata_i; // R12
	end

	// Per-drive settings, identical layout for both drives.
	fpcr_drive_reg u_drive_zero
	(
		.clk_sys_i           (clk_sys_i),
		.rst_b_i             (regs_rst_b),
		.wr_en_i             (wr_floppy && index_i == IDX_DRIVE_ZERO),
		.wr_data_i           (cfg_wdata_i),
		.value_o             (drive_zero_settings),
		.drive_type_select_o (d0_type),
		.rate_table_select_o (d0_rate),
		.precomp_disable_o   (d0_precomp)
	); // R14

	fpcr_drive_reg u_drive_one
	(
		.clk_sys_i           (clk_sys_i),
		.rst_b_i             (regs_rst_b),
		.wr_en_i             (wr_floppy && index_i == IDX_DRIVE_ONE),
		.wr_data_i           (cfg_wdata_i),
		.value_o             (drive_one_settings),
		.drive_type_select_o (d1_type),
		.rate_table_select_o (d1_rate),
		.precomp_disable_o   (d1_precomp)
	); // R16

	// -----------------------------------------------------------
	// Parallel port registers
	// -----------------------------------------------------------

	// Mode and FIFO threshold.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
			parallel_mode_cfg_q <= RST_PARALLEL_MODE; // R18
		else if (wr_pport && index_i == IDX_MODE)
			parallel_mode_cfg_q <= cfg_wdata_i; // R17
	end

	// Floppy routing; reserved bits are kept as written.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
			parallel_floppy_routing_q <= RST_ROUTING;
		else if (wr_pport && index_i == IDX_OPTION)
			parallel_floppy_routing_q <= cfg_wdata_i; // R22
	end

	// -----------------------------------------------------------
	// Read path
	// -----------------------------------------------------------

	// Unknown indices and devices read as zero, like the reserved F3 slot.
	always_comb
	begin
		rdata_d = ZERO_BYTE;
		if (sel_floppy)
		begin
			unique case (index_i)
				IDX_MODE:        rdata_d = floppy_mode_cfg_q;
				IDX_OPTION:      rdata_d = floppy_option_cfg_q;
				IDX_DRIVE_TYPES: rdata_d = floppy_drive_types_q;
				IDX_RESERVED_F3: rdata_d = ZERO_BYTE; // R13
				IDX_DRIVE_ZERO:  rdata_d = drive_zero_settings; // R24
				IDX_DRIVE_ONE:   rdata_d = drive_one_settings;
				default:         rdata_d = ZERO_BYTE;
			endcase
		end
		else if (sel_pport)
		begin
			unique case (index_i)
				IDX_MODE:   rdata_d = parallel_mode_cfg_q;
				IDX_OPTION: rdata_d = parallel_floppy_routing_q;
				default:    rdata_d = ZERO_BYTE;
			endcase
		end
	end

	// Read data is registered; it answers one cycle after the strobe.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			cfg_rdata_o  <= ZERO_BYTE;
			cfg_rvalid_o <= 1'b0;
		end
		else
		begin
			cfg_rdata_o  <= cfg_rd_i ? rdata_d : ZERO_BYTE;
			cfg_rvalid_o <= cfg_rd_i;
		end
	end

	// -----------------------------------------------------------
	// Strap capture
	// -----------------------------------------------------------

	// The strap pin passes two flops while reset is held, then both hold so
	// the port address does not move if the pin later changes.
	always_ff @(posedge clk_sys_i)
	begin
		if (!regs_rst_b)
		begin
			strap_meta_q      <= config_port_strap_i;
			config_port_alt_o <= strap_meta_q; // R23
		end
	end

	// -----------------------------------------------------------
	// Derived controls
	// -----------------------------------------------------------
	assign any_drive_sel = |drive_select_i;
	assign pp_irq_valid  = (parallel_mode_cfg_q[PM_MODE_LO +: 3] != PMODE_PRINTER) &&
	                       (parallel_mode_cfg_q[PM_MODE_LO +: 3] != PMODE_SPP); // R20

	// Interrupt style: none when not valid, else pulsed or following.
	always_comb
	begin
		if (!pp_irq_valid)
			irq_style_d = FPCR_IRQ_NONE;
		else if (parallel_mode_cfg_q[PM_PULSE_IRQ])
			irq_style_d = FPCR_IRQ_PULSE; // R19
		else
			irq_style_d = FPCR_IRQ_FOLLOW;
	end

	// Floppy controls, registered so outputs come from flip-flops.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			floppy_enhanced_o       <= 1'b0;
			floppy_non_burst_o      <= RST_FLOPPY_MODE[FM_NON_BURST];
			floppy_iface_mode_o     <= RST_FLOPPY_MODE[FM_IFACE_LO +: 2];
			floppy_pins_push_pull_o <= 1'b0;
			floppy_pins_tristate_o  <= 1'b0;
			floppy_drive_types_o    <= RST_DRIVE_TYPES;
			boot_drive_o            <= BOOT_DRIVE;
		end
		else
		begin
			floppy_enhanced_o       <= floppy_mode_cfg_q[FM_ENHANCED]; // R2
			floppy_non_burst_o      <= floppy_mode_cfg_q[FM_NON_BURST]; // R3
			floppy_iface_mode_o     <= floppy_mode_cfg_q[FM_IFACE_LO +: 2]; // R4
			floppy_pins_push_pull_o <= floppy_mode_cfg_q[FM_PUSH_PULL]; // R5
			floppy_pins_tristate_o  <= floppy_mode_cfg_q[FM_TRISTATE]; // R6
			floppy_drive_types_o    <= floppy_drive_types_q;
			boot_drive_o            <= BOOT_DRIVE; // R11
		end
	end

	// Per-drive fields.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			drive0_type_select_o       <= 2'h0;
			drive0_rate_table_select_o <= 2'h0;
			drive0_precomp_disable_o   <= 1'b0;
			drive1_type_select_o       <= 2'h0;
			drive1_rate_table_select_o <= 2'h0;
			drive1_precomp_disable_o   <= 1'b0;
		end
		else
		begin
			drive0_type_select_o       <= d0_type;
			drive0_rate_table_select_o <= d0_rate;
			drive0_precomp_disable_o   <= d0_precomp; // R15
			drive1_type_select_o       <= d1_type;
			drive1_rate_table_select_o <= d1_rate;
			drive1_precomp_disable_o   <= d1_precomp;
		end
	end

	// Write protect to the core covers both pin sets, since the override is
	// applied after routing and before the core sees it.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			write_protect_core_n_o <= 1'b1;
		else if (floppy_option_cfg_q[FO_FORCE_WP] && any_drive_sel)
			write_protect_core_n_o <= 1'b0; // R8 R9
		else
			write_protect_core_n_o <= wp_sync;
	end

	// Density override.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
			density_o <= 1'b0;
		else if (floppy_option_cfg_q[FO_DENS_LO +: 2] == DENS_FORCE_ONE)
			density_o <= 1'b1; // R10
		else if (floppy_option_cfg_q[FO_DENS_LO +: 2] == DENS_FORCE_ZERO)
			density_o <= 1'b0;
		else
			density_o <= dens_sync;
	end

	// Parallel controls and floppy routing. The driver style and tristate
	// controls above never reach the parallel pins.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_b_i)
		begin
			pport_mode_o         <= PMODE_PRINTER;
			ecp_fifo_threshold_o <= RST_PARALLEL_MODE[PM_THRESH_LO +: 4];
			pport_irq_style_o    <= FPCR_IRQ_NONE;
			drive0_on_pport_o    <= 1'b0;
			drive1_on_pport_o    <= 1'b0;
			pport_floppy_route_o <= 1'b0;
		end
		else
		begin
			pport_mode_o         <= parallel_mode_cfg_q[PM_MODE_LO +: 3];
			ecp_fifo_threshold_o <= parallel_mode_cfg_q[PM_THRESH_LO +: 4];
			pport_irq_style_o    <= irq_style_d;
			drive0_on_pport_o    <= (parallel_floppy_routing_q[PR_ROUTE_LO +: 2] == ROUTE_ALL_PPORT); // R21
			drive1_on_pport_o    <= (parallel_floppy_routing_q[PR_ROUTE_LO +: 2] == ROUTE_SPLIT) ||
			                        (parallel_floppy_routing_q[PR_ROUTE_LO +: 2] == ROUTE_ALL_PPORT);
			pport_floppy_route_o <= (parallel_floppy_routing_q[PR_ROUTE_LO +: 2] != ROUTE_NORMAL); // R7
		end
	end

endmodule

/* File: verification/fpcr_top_sva.sv */
`timescale 1ns/100ps
module fpcr_top_sva
	import fpcr_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	// Configuration access
	input wire logic [7:0] ldn_i,
	input wire logic [7:0] index_i,
	input wire logic       cfg_wr_i,
	input wire logic       cfg_rd_i,
	input wire logic [7:0] cfg_wdata_i,
	input wire logic [7:0] cfg_rdata_o,
	input wire logic       cfg_rvalid_o,
	// Floppy controls
	input wire logic       floppy_enhanced_o,
	input wire logic       floppy_non_burst_o,
	input wire logic [1:0] floppy_iface_mode_o,
	input wire logic       floppy_pins_push_pull_o,
	input wire logic       floppy_pins_tristate_o,
	input wire logic [1:0] boot_drive_o,
	input wire logic [1:0] drive0_type_select_o,
	input wire logic [1:0] drive0_rate_table_select_o,
	input wire logic       drive0_precomp_disable_o,
	input wire logic       density_o,
	// Parallel port controls
	input wire logic [2:0] pport_mode_o,
	input wire logic [3:0] ecp_fifo_threshold_o,
	input wire logic [2:0] pport_irq_style_o,
	input wire logic       drive0_on_pport_o,
	input wire logic       drive1_on_pport_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	// Device decode; a same-register write in the next cycle reaches the output only after the check, so checks need no spacing.
	logic fl;
	logic pp;
	assign fl = ldn_i == LDN_FLOPPY;
	assign pp = ldn_i == LDN_PPORT;

	a_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o)
		else $error("read got no answer");
	a_idle_quiet: assert property (!cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == ZERO_BYTE)
		else $error("read data without a read");
	a_reserved_zero: assert property (cfg_rd_i && fl && index_i == IDX_RESERVED_F3 |=> cfg_rdata_o == ZERO_BYTE)
		else $error("reserved index read non-zero");
	a_drive_ro_zero: assert property (cfg_rd_i && fl && index_i[7:1] == 7'h7A
		|=> (cfg_rdata_o & ~MASK_DRIVE_SETTINGS) == ZERO_BYTE)
		else $error("read-only drive bits non-zero");
	a_floppy_mode_out: assert property (cfg_wr_i && fl && index_i == IDX_MODE |-> ##2
		{floppy_pins_tristate_o, floppy_pins_push_pull_o, floppy_iface_mode_o, floppy_non_burst_o, floppy_enhanced_o}
		== {$past(cfg_wdata_i[7:6], 2), $past(cfg_wdata_i[3:0], 2)})
		else $error("floppy mode outputs wrong");
	a_density_forced: assert property (cfg_wr_i && fl && index_i == IDX_OPTION && cfg_wdata_i[3]
		|-> ##2 density_o == !$past(cfg_wdata_i[2], 2))
		else $error("density override wrong");
	a_drive_fields: assert property (cfg_wr_i && fl && index_i == IDX_DRIVE_ZERO |-> ##2
		{drive0_precomp_disable_o, drive0_rate_table_select_o, drive0_type_select_o}
		== {$past(cfg_wdata_i[6], 2), $past(cfg_wdata_i[4:3], 2), $past(cfg_wdata_i[1:0], 2)})
		else $error("drive zero fields wrong");
	a_pport_mode_out: assert property (cfg_wr_i && pp && index_i == IDX_MODE
		|-> ##2 {ecp_fifo_threshold_o, pport_mode_o} == {$past(cfg_wdata_i[6:3], 2), $past(cfg_wdata_i[2:0], 2)})
		else $error("parallel mode outputs wrong");
	a_irq_ignored: assert property (pport_mode_o == PMODE_PRINTER || pport_mode_o == PMODE_SPP
		|-> pport_irq_style_o == FPCR_IRQ_NONE)
		else $error("interrupt style active in printer or standard mode");
	a_route_pins: assert property (cfg_wr_i && pp && index_i == IDX_OPTION && cfg_wdata_i[1:0] != 2'h3 |-> ##2
		{drive0_on_pport_o, drive1_on_pport_o}
		== {$past(cfg_wdata_i[1:0], 2) == ROUTE_ALL_PPORT, $past(cfg_wdata_i[1:0], 2) != ROUTE_NORMAL})
		else $error("drive routing wrong");
	a_boot_zero: assert property (boot_drive_o == BOOT_DRIVE)
		else $error("boot drive not zero");

	c_reserved_read: cover property (cfg_rd_i && fl && index_i == IDX_RESERVED_F3);
	c_pulse_irq: cover property (pport_irq_style_o == FPCR_IRQ_PULSE);
	c_all_on_pport: cover property (drive0_on_pport_o);
endmodule

bind fpcr_top fpcr_top_sva i_sva (.*);

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb
	import fpcr_pkg::*;
;
	logic       clk_sys_i = 1'b0;
	logic       rst_b_i = 1'b0;
	logic       hard_reset_b_i = 1'b1;
	logic       cfg_wr_i = 1'b0;
	logic       cfg_rd_i = 1'b0;
	logic       config_port_strap_i = 1'b1;
	logic       write_protect_in_n_i = 1'b1;
	logic       density_core_i = 1'b0;
	logic [1:0] drive_select_i = 2'h0;
	logic [7:0] ldn_i = 8'h00;
	logic [7:0] index_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic [7:0] cfg_rdata_o, floppy_drive_types_o;
	logic       cfg_rvalid_o, config_port_alt_o, floppy_enhanced_o, floppy_non_burst_o, floppy_pins_push_pull_o;
	logic       floppy_pins_tristate_o, drive0_precomp_disable_o, drive1_precomp_disable_o, write_protect_core_n_o;
	logic       density_o, drive0_on_pport_o, drive1_on_pport_o, pport_floppy_route_o;
	logic [1:0] floppy_iface_mode_o, boot_drive_o, drive0_type_select_o, drive0_rate_table_select_o;
	logic [1:0] drive1_type_select_o, drive1_rate_table_select_o;
	logic [2:0] pport_mode_o, pport_irq_style_o;
	logic [3:0] ecp_fifo_threshold_o;
	int         failures = 0;
	int         n_compared = 0;
	localparam logic [23:0] DEFAULTS [8] = '{{LDN_FLOPPY, IDX_MODE, 8'h0E}, {LDN_FLOPPY, IDX_OPTION, 8'h00},
		{LDN_FLOPPY, IDX_DRIVE_TYPES, 8'hFF}, {LDN_FLOPPY, IDX_RESERVED_F3, 8'h00}, {LDN_FLOPPY, IDX_DRIVE_ZERO, 8'h00},
		{LDN_FLOPPY, IDX_DRIVE_ONE, 8'h00}, {LDN_PPORT, IDX_MODE, 8'h3C}, {LDN_PPORT, IDX_OPTION, 8'h00}};

	fpcr_top i_dut (.*);

	// Free-running system clock, 40 ns period.
	initial
		forever #20 clk_sys_i = ~clk_sys_i;

	// ---------------------------------------------------------------
	// Access and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Writes return only once the control outputs have settled, two edges after the strobe.
	task automatic wr(logic [7:0] ldn, logic [7:0] idx, logic [7:0] data);
		@(negedge clk_sys_i);
		ldn_i = ldn;
		index_i = idx;
		cfg_wdata_i = data;
		cfg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		cfg_wr_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
	endtask

	// The answer stands for one cycle only, so it is sampled at the next falling edge.
	task automatic rd(logic [7:0] ldn, logic [7:0] idx, logic [7:0] exp);
		@(negedge clk_sys_i);
		ldn_i = ldn;
		index_i = idx;
		cfg_rd_i = 1'b1;
		@(negedge clk_sys_i);
		cfg_rd_i = 1'b0;
		chk("rvalid", 16'h0001, {15'h0000, cfg_rvalid_o});
		chk($sformatf("rdata %h.%h", ldn, idx), {8'h00, exp}, {8'h00, cfg_rdata_o});
	endtask

	task automatic defaults();
		foreach (DEFAULTS[i])
			rd(DEFAULTS[i][23:16], DEFAULTS[i][15:8], DEFAULTS[i][7:0]);
		chk("floppy and pport", {6'h1C, PMODE_PRINTER, 4'h7, FPCR_IRQ_NONE}, {floppy_enhanced_o,
			floppy_non_burst_o, floppy_iface_mode_o, floppy_pins_push_pull_o, floppy_pins_tristate_o, pport_mode_o,
			ecp_fifo_threshold_o, pport_irq_style_o});
		chk("types and pins", 16'hFF03, {floppy_drive_types_o, boot_drive_o, drive0_on_pport_o,
			drive1_on_pport_o, pport_floppy_route_o, density_o, write_protect_core_n_o, config_port_alt_o});
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog; the sequence needs well under a thousand cycles.
	initial
	begin
		#(40 * 4000);
		failures++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial
	begin
		logic [7:0] v;
		logic [1:0] m;
		repeat (13) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		defaults();
		// Floppy mode fields; bit five stays zero as software must keep it.
		for (int i = 0; i < 2; i++)
		begin
			v = i ? 8'h46 : 8'h81;
			wr(LDN_FLOPPY, IDX_MODE, v);
			chk("floppy mode", {10'h000, v[7:6], v[3:0]}, {10'h000, floppy_pins_tristate_o,
				floppy_pins_push_pull_o, floppy_iface_mode_o, floppy_non_burst_o, floppy_enhanced_o});
			rd(LDN_FLOPPY, IDX_MODE, v);
		end
		// Per-drive registers drop writes to their read-only bits.
		wr(LDN_FLOPPY, IDX_DRIVE_ZERO, 8'hFF);
		wr(LDN_FLOPPY, IDX_DRIVE_ONE, 8'hC9);
		rd(LDN_FLOPPY, IDX_DRIVE_ZERO, 8'h5B);
		rd(LDN_FLOPPY, IDX_DRIVE_ONE, 8'h49);
		chk("drive fields", 16'h1F15, {3'h0, drive0_precomp_disable_o, drive0_rate_table_select_o,
			drive0_type_select_o, 3'h0, drive1_precomp_disable_o, drive1_rate_table_select_o, drive1_type_select_o});
		wr(LDN_FLOPPY, IDX_DRIVE_TYPES, 8'h5A);
		rd(LDN_FLOPPY, IDX_DRIVE_TYPES, 8'h5A);
		chk("drive types", 16'h005A, {8'h00, floppy_drive_types_o});
		// Reserved index and unknown device.
		wr(LDN_FLOPPY, IDX_RESERVED_F3, 8'hFF);
		rd(LDN_FLOPPY, IDX_RESERVED_F3, 8'h00);
		wr(8'h05, IDX_MODE, 8'hAA);
		rd(8'h05, IDX_MODE, 8'h00);
		rd(LDN_FLOPPY, IDX_MODE, 8'h46);
		// Density override against both core levels.
		for (int i = 0; i < 8; i++)
		begin
			m = i[1:0];
			density_core_i = i[2];
			wr(LDN_FLOPPY, IDX_OPTION, {4'h0, m, 2'h0});
			repeat (3) @(negedge clk_sys_i);
			chk("density", {15'h0000, m == 2'h2 || (m != 2'h3 && i[2])}, {15'h0000, density_o});
		end
		// Forced write protect against every drive select.
		for (int j = 0; j < 8; j++)
		begin
			drive_select_i = j[2:1];
			wr(LDN_FLOPPY, IDX_OPTION, {7'h00, j[0]});
			repeat (4) @(negedge clk_sys_i);
			chk("write protect", {15'h0000, !(j[0] && j[2:1] != 2'h0)}, {15'h0000, write_protect_core_n_o});
		end
		// Every port mode except 6 with a pulsed interrupt, then one following style.
		for (int k = 0; k < 8; k++)
		begin
			v = {1'b1, 4'(15 - k), 3'(k)};
			if (k != 6)
			begin
				wr(LDN_PPORT, IDX_MODE, v);
				chk("pport mode", {5'h00, v[6:0], 1'b0, (k == 0 || k == 4) ? FPCR_IRQ_NONE : FPCR_IRQ_PULSE},
					{5'h00, ecp_fifo_threshold_o, pport_mode_o, 1'b0, pport_irq_style_o});
				rd(LDN_PPORT, IDX_MODE, v);
			end
		end
		wr(LDN_PPORT, IDX_MODE, {1'b0, 4'h7, PMODE_ECP});
		chk("irq follow", {13'h0000, FPCR_IRQ_FOLLOW}, {13'h0000, pport_irq_style_o});
		// Drive routing; the forced write protect is still set.
		for (int r = 0; r < 3; r++)
		begin
			wr(LDN_PPORT, IDX_OPTION, 8'(r));
			rd(LDN_PPORT, IDX_OPTION, 8'(r));
			chk("routing", {13'h0000, r == 2, r != 0, r != 0}, {13'h0000, drive0_on_pport_o,
				drive1_on_pport_o, pport_floppy_route_o});
			chk("wp routed", 16'h0000, {15'h0000, write_protect_core_n_o});
		end
		// Hard reset brings every register back.
		density_core_i = 1'b0;
		hard_reset_b_i = 1'b0;
		repeat (4) @(negedge clk_sys_i);
		hard_reset_b_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		defaults();
		conclude();
	end
endmodule
